/* File: core/fcoe_top.sv */
// Output enable and power control of an eight-output clock fanout buffer.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "fcoe_defs.svh"
module fcoe_top (
	input  wire logic                        clk,
	input  wire logic                        arst_n,
	input  wire logic                        interface_mode_select,
	input  wire logic                        serial_shift_clock,
	input  wire logic                        serial_data_input,
	input  wire logic                        serial_latch_strobe,
	input  wire logic                        chip_power_enable,
	input  wire logic [`FCOE_ADDR_W-1:0]     avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire fcoe_pkg::fcoe_word_t        avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output fcoe_pkg::fcoe_word_t             avs_readdata,
	output logic                             avs_waitrequest,
	output fcoe_pkg::fcoe_drv_mask_t         driver_enable,
	output fcoe_pkg::fcoe_drv_mask_t         output_switch_close,
	output logic                             input_switch_close,
	output logic                             power_down,
	output logic                             term_150_select,
	output logic                             internal_bias_enable
);
	import fcoe_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers.

	// An accepted write hits one register when its address matches exactly.
	// Byte addresses are compared whole, so aliases of a register are refused.
	function automatic logic wr_hit(
		input logic                    take,
		input logic [`FCOE_ADDR_W-1:0] addr,
		input logic [`FCOE_ADDR_W-1:0] ofs
	);
		return take && (addr == ofs);
	endfunction : wr_hit

	////////////////////////////////////////////////////////////////////////////////
	// Reset and pin synchronisation.

	logic                   rst_meta;   // First reset stage.
	logic                   rst_n;      // Released reset used everywhere else.
	logic [`FCOE_PIN_W-1:0] pins_raw;   // Control pins as they arrive.
	logic [`FCOE_PIN_W-1:0] pins_s;     // Control pins after two flops.
	logic                   mode_s;     // High selects parallel control.
	logic                   chip_en_s;  // Hardware power enable level.
	fcoe_code_t             code_s;     // Parallel enable code.
	fcoe_drv_mask_t         par_mask;   // Drivers the code asks for.

	// Assert at once, release through two flops so no flop sees a ragged edge.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Pins are bundled so one synchroniser instance serves them all.
	assign pins_raw[`FCOE_PIN_LATCH]   = serial_latch_strobe;
	assign pins_raw[`FCOE_PIN_DATA]    = serial_data_input;
	assign pins_raw[`FCOE_PIN_SHIFT]   = serial_shift_clock;
	assign pins_raw[`FCOE_PIN_MODE]    = interface_mode_select;
	assign pins_raw[`FCOE_PIN_CHIP_EN] = chip_power_enable;

	fcoe_sync u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (pins_raw),
		.q     (pins_s)
	);

	assign mode_s    = pins_s[`FCOE_PIN_MODE];
	assign chip_en_s = pins_s[`FCOE_PIN_CHIP_EN];
	// Shift clock is the most significant code bit, latch strobe the least.
	assign code_s    = {pins_s[`FCOE_PIN_SHIFT], pins_s[`FCOE_PIN_DATA],
		pins_s[`FCOE_PIN_LATCH]};

	// The code is decoded as a level, with no strobe or edge involved.
	fcoe_code_map u_code_map (
		.code (code_s),
		.mask (par_mask)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave.

	fcoe_bus_state_t bus_state;   // Handshake state.
	logic [7:0]      power_reg;   // Power control register.
	logic [7:0]      out_en_reg;  // Output enable register.
	logic [7:0]      cfg_reg;     // Input configuration register.
	logic            wr_take;     // Write accepted this edge.
	logic            lane0;       // Low byte lane is written.
	logic            power_ok;    // Pin and register both allow power.
	fcoe_word_t      next_readdata; // Read answer for the current address.

	// Only the low byte holds data, so only byte lane 0 can change a register.
	assign lane0   = avs_byteenable[0];
	assign wr_take = avs_write && !avs_waitrequest && lane0;

	// One wait cycle per request: the request is seen, then answered once.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_state       <= BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			case (bus_state)
				BUS_IDLE: begin
					// A pending request is answered at the next edge.
					if (avs_read || avs_write) begin
						bus_state       <= BUS_ACK;
						avs_waitrequest <= 1'b0;
					end
				end
				BUS_ACK: begin
					// Back to waiting so the next request gets a fresh answer.
					bus_state       <= BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					bus_state       <= BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Read mux; unmapped addresses and reserved bits answer zero.
	always_comb begin
		next_readdata = '0;
		case (avs_address)
			`FCOE_OFS_POWER:      next_readdata[7:0] = power_reg;
			`FCOE_OFS_OUT_ENABLE: next_readdata[7:0] = out_en_reg;
			`FCOE_OFS_IN_CONFIG:  next_readdata[7:0] = cfg_reg;
			`FCOE_OFS_STATUS: begin
				next_readdata[`FCOE_ST_POWER_BIT] = power_ok;
				next_readdata[`FCOE_ST_MODE_BIT]  = mode_s;
				next_readdata[`FCOE_ST_PIN_BIT]   = chip_en_s;
				next_readdata[`FCOE_ST_DRV_MSB:`FCOE_ST_DRV_LSB] = driver_enable;
			end
			default:              next_readdata = '0;
		endcase
	end

	// Read data is captured as waitrequest falls, so it stands at the answer edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= '0;
		end else if (bus_state == BUS_IDLE && avs_read) begin
			avs_readdata <= next_readdata;
		end
	end

	// Power control register; writes land even while the enable pin is low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_reg <= `FCOE_RST_POWER;
		end else if (wr_hit(wr_take, avs_address, `FCOE_OFS_POWER)) begin
			power_reg <= {7'h00, avs_writedata[`FCOE_PWR_EN_BIT]};
		end
	end

	// Output enable register, one bit per driver.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_en_reg <= `FCOE_RST_OUT_ENABLE;
		end else if (wr_hit(wr_take, avs_address, `FCOE_OFS_OUT_ENABLE)) begin
			out_en_reg <= avs_writedata[7:0];
		end
	end

	// Input configuration register; only the termination and bias bits exist.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= `FCOE_RST_IN_CONFIG;
		end else if (wr_hit(wr_take, avs_address, `FCOE_OFS_IN_CONFIG)) begin
			cfg_reg <= avs_writedata[7:0] & `FCOE_CFG_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output control.

	// The pin has no pull, so the host is trusted to drive it; either off wins.
	assign power_ok = chip_en_s && power_reg[`FCOE_PWR_EN_BIT];

	// Driver set: parallel code, or register bits, and nothing while powered down.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			driver_enable <= '0;
		end else if (!power_ok) begin
			driver_enable <= '0;
		end else if (mode_s) begin
			driver_enable <= par_mask;
		end else begin
			driver_enable <= out_en_reg;
		end
	end

	// Each output switch closes only for an enabled driver.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			output_switch_close <= '0;
		end else if (!power_ok) begin
			output_switch_close <= '0;
		end else if (mode_s) begin
			output_switch_close <= par_mask;
		end else begin
			output_switch_close <= out_en_reg;
		end
	end

	// Power-down opens the input switch as well.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_down         <= 1'b1;
			input_switch_close <= 1'b0;
		end else begin
			power_down         <= !power_ok;
			input_switch_close <= power_ok;
		end
	end

	// Analog configuration follows the register in either control mode.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			term_150_select      <= 1'b0;
			internal_bias_enable <= 1'b1;
		end else begin
			term_150_select      <= cfg_reg[`FCOE_CFG_TERM_BIT];
			internal_bias_enable <= cfg_reg[`FCOE_CFG_BIAS_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Parallel code picks its cumulative set.
	a_par_set: assert property (mode_s && power_ok |=>
		driver_enable == $past(par_mask))
		else $error("parallel driver set wrong");

	// Code change is followed within one edge, no strobe needed.
	a_par_level: assert property (mode_s && power_ok && $changed(code_s)
		&& $stable(mode_s) && $stable(power_ok) |=> $changed(driver_enable))
		else $error("parallel code change ignored");

	// Serial mode copies the register.
	a_ser_set: assert property (!mode_s && power_ok |=>
		driver_enable == $past(out_en_reg))
		else $error("serial driver set wrong");

	// Power-down opens the input switch and clears every driver enable.
	a_power_down: assert property (!power_ok |=>
		power_down && !input_switch_close && driver_enable == '0)
		else $error("power-down incomplete");

	// Writing zero to the enable bit stops drivers two edges later.
	a_pwr_write: assert property (wr_take && avs_address == `FCOE_OFS_POWER
		&& !avs_writedata[`FCOE_PWR_EN_BIT] |=> ##1 driver_enable == '0)
		else $error("power bit zero did not disable");

	// Write with pin low still lands in the output enable register.
	a_pin_low_wr: assert property (!chip_en_s && wr_take
		&& avs_address == `FCOE_OFS_OUT_ENABLE |=> out_en_reg == $past(avs_writedata[7:0]))
		else $error("write lost while pin low");

	// Drivers only while pin and bit both allowed one edge before.
	a_both_need: assert property (driver_enable != '0 |->
		$past(chip_en_s) && $past(power_reg[`FCOE_PWR_EN_BIT]))
		else $error("driver active without both enables");

	// Termination follows a configuration write two edges later.
	a_term_sel: assert property (wr_take && avs_address == `FCOE_OFS_IN_CONFIG
		|=> ##1 term_150_select == $past(avs_writedata[`FCOE_CFG_TERM_BIT], 2))
		else $error("termination select wrong");

	// Bias follows a configuration write two edges later.
	a_bias_sel: assert property (wr_take && avs_address == `FCOE_OFS_IN_CONFIG
		|=> ##1 internal_bias_enable == $past(avs_writedata[`FCOE_CFG_BIAS_BIT], 2))
		else $error("bias select wrong");

	// Every driver switch matches its driver.
	a_switch_open: assert property (output_switch_close == driver_enable)
		else $error("switch state differs from driver");

	// A request is answered on the next edge and the answer lasts one cycle.
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");

	// A steady code in steady conditions leaves the driver set alone.
	a_par_hold: assert property (mode_s && power_ok && $stable(code_s)
		&& $stable(mode_s) && $stable(power_ok) |=> $stable(driver_enable))
		else $error("parallel set moved without a code change");

	// A powered part closes its input switch at the next edge.
	a_power_up: assert property (power_ok |=> !power_down && input_switch_close)
		else $error("powered part still switched off");

	// A read of the power register answers with its stored enable bit.
	a_rd_power: assert property (avs_read && !avs_waitrequest
		&& avs_address == `FCOE_OFS_POWER |-> avs_readdata == {24'h000000, power_reg})
		else $error("power register read wrong");

	// A read of the output enable register answers with its stored bits.
	a_rd_out_en: assert property (avs_read && !avs_waitrequest
		&& avs_address == `FCOE_OFS_OUT_ENABLE |-> avs_readdata == {24'h000000, out_en_reg})
		else $error("output enable register read wrong");

	// A read of the configuration register answers with its stored bits.
	a_rd_cfg: assert property (avs_read && !avs_waitrequest
		&& avs_address == `FCOE_OFS_IN_CONFIG |-> avs_readdata == {24'h000000, cfg_reg})
		else $error("configuration register read wrong");

	// Only the termination and bias bits of the configuration can be set.
	a_cfg_bits: assert property ((cfg_reg & ~`FCOE_CFG_MASK) == 8'h00)
		else $error("reserved configuration bit set");

	// Only the enable bit of the power register can be set.
	a_pwr_bits: assert property (power_reg[7:1] == 7'h00)
		else $error("reserved power bit set");

	// A write without the low byte lane leaves every register untouched.
	a_lane_guard: assert property (avs_write && !avs_waitrequest && !lane0
		|=> $stable(power_reg) && $stable(out_en_reg) && $stable(cfg_reg))
		else $error("write landed without its byte lane");

	c_par_all: cover property (mode_s && power_ok && code_s == 3'h7 ##1
		driver_enable == `FCOE_PAR_MASK_7);
	c_ser_write: cover property (wr_take && avs_address == `FCOE_OFS_OUT_ENABLE);
	c_cfg_write: cover property (wr_hit(wr_take, avs_address, `FCOE_OFS_IN_CONFIG));
	c_pin_low_wr: cover property (!chip_en_s && wr_take ##[1:20] power_ok);
	c_status_rd: cover property (avs_read && !avs_waitrequest
		&& avs_address == `FCOE_OFS_STATUS);

endmodule : fcoe_top

/* File: core/fcoe_defs.svh */
// Constants of the fanout output enable control: offsets, fields, reset values, masks.
// Behaviour
// - Mode pin high: three pins form code
// - Codes add drivers 2,7,4,6,5,3,8,1 cumulatively
// - Mode pin low: one enable bit per driver
// - Either power control disabling powers everything down; term_150_select and internal_bias_enable still follow the register
// - One configuration bit selects 50/150 ohm termination
// - Bias bit set generates 2.0 V bias, resets set
// - Enable pin low: writes still land, apply later
// - Power enable bit resets one; zero disables
// - Drivers run only when pin and bit allow
// - Disabled driver has its output switch open
`ifndef FCOE_DEFS_SVH
`define FCOE_DEFS_SVH

// Register byte offsets on the bus.
`define FCOE_ADDR_W         8
`define FCOE_OFS_POWER      8'h00
`define FCOE_OFS_OUT_ENABLE 8'h04
`define FCOE_OFS_IN_CONFIG  8'h08
`define FCOE_OFS_STATUS     8'h0c

// Field positions.
`define FCOE_PWR_EN_BIT     0
`define FCOE_CFG_TERM_BIT   3
`define FCOE_CFG_BIAS_BIT   1
`define FCOE_CFG_MASK       8'h0a
`define FCOE_ST_POWER_BIT   0
`define FCOE_ST_MODE_BIT    1
`define FCOE_ST_PIN_BIT     2
`define FCOE_ST_DRV_LSB     8
`define FCOE_ST_DRV_MSB     15

// Reset values.
`define FCOE_RST_POWER      8'h01
`define FCOE_RST_OUT_ENABLE 8'hff
`define FCOE_RST_IN_CONFIG  8'h02

// Cumulative driver sets for each parallel code; bit k is clock_driver_(k+1).
`define FCOE_PAR_MASK_0     8'h02
`define FCOE_PAR_MASK_1     8'h42
`define FCOE_PAR_MASK_2     8'h4a
`define FCOE_PAR_MASK_3     8'h6a
`define FCOE_PAR_MASK_4     8'h7a
`define FCOE_PAR_MASK_5     8'h7e
`define FCOE_PAR_MASK_6     8'hfe
`define FCOE_PAR_MASK_7     8'hff

// Pin bundle positions inside the synchroniser.
`define FCOE_PIN_W          5
`define FCOE_PIN_LATCH      0
`define FCOE_PIN_DATA       1
`define FCOE_PIN_SHIFT      2
`define FCOE_PIN_MODE       3
`define FCOE_PIN_CHIP_EN    4

`endif

/* File: core/fcoe_pkg.sv */
// Types shared by the fanout output enable control.
package fcoe_pkg;
	typedef logic [7:0]  fcoe_drv_mask_t; // One bit per clock driver.
	typedef logic [2:0]  fcoe_code_t;     // Parallel enable code.
	typedef logic [31:0] fcoe_word_t;     // Bus data word.
	// Bus handshake state: waiting for a request, or answering it.
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} fcoe_bus_state_t;
endpackage : fcoe_pkg

/* File: core/fcoe_sync.sv */
// Two-flop synchroniser for the control pins.
`timescale 1ns/100ps
`include "fcoe_defs.svh"
module fcoe_sync (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic [`FCOE_PIN_W-1:0] d,
	output logic      [`FCOE_PIN_W-1:0] q
);
	import fcoe_pkg::*;
	logic [`FCOE_PIN_W-1:0] stage1; // Only the second stage reads this.

	// Reset to zero so the part comes up powered down until the pin is seen.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			q      <= '0;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end
endmodule : fcoe_sync

/* File: core/fcoe_code_map.sv */
// Decoder from the parallel code to its cumulative driver set.
`timescale 1ns/100ps
`include "fcoe_defs.svh"
module fcoe_code_map (
	input  wire fcoe_pkg::fcoe_code_t code,
	output fcoe_pkg::fcoe_drv_mask_t  mask
);
	import fcoe_pkg::*;

	// Pure level decode; each code adds one driver to the one below it.
	always_comb begin
		case (code)
			3'h0:    mask = `FCOE_PAR_MASK_0;
			3'h1:    mask = `FCOE_PAR_MASK_1;
			3'h2:    mask = `FCOE_PAR_MASK_2;
			3'h3:    mask = `FCOE_PAR_MASK_3;
			3'h4:    mask = `FCOE_PAR_MASK_4;
			3'h5:    mask = `FCOE_PAR_MASK_5;
			3'h6:    mask = `FCOE_PAR_MASK_6;
			3'h7:    mask = `FCOE_PAR_MASK_7;
			default: mask = `FCOE_PAR_MASK_0;
		endcase
	end
endmodule : fcoe_code_map

/* File: verif/fcoe_host.sv */
// Host controller model: drives the control pins and masters the register bus.
`timescale 1ns/100ps
module fcoe_host (
	input  wire logic            clk,
	input  wire logic            avs_waitrequest,
	output logic                 interface_mode_select,
	output logic                 serial_shift_clock,
	output logic                 serial_data_input,
	output logic                 serial_latch_strobe,
	output logic                 chip_power_enable,
	output logic [7:0]           avs_address,
	output logic                 avs_read,
	output logic                 avs_write,
	output fcoe_pkg::fcoe_word_t avs_writedata,
	output logic [3:0]           avs_byteenable
);
	import fcoe_pkg::*;
	////////////////////////////////////////////////////////////////
	// The enable pin has no pull, so it is driven from time zero onward.
	initial begin
		chip_power_enable     = 1'b1;
		interface_mode_select = 1'b0;
		{serial_shift_clock, serial_data_input, serial_latch_strobe} = 3'h0;
		{avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
	end
	// Pins are static levels, changed just after a rising edge.
	task automatic pins(input logic m, input logic [2:0] c, input logic e);
		interface_mode_select <= m;
		{serial_shift_clock, serial_data_input, serial_latch_strobe} <= c;
		chip_power_enable <= e;
	endtask : pins
	// One bus access; the request is held until waitrequest is seen low.
	task automatic xfer(input logic w, input logic [7:0] a, input fcoe_word_t d,
		input logic [3:0] b);
		avs_address    <= a;
		avs_write      <= w;
		avs_read       <= ~w;
		avs_writedata  <= d;
		avs_byteenable <= b;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		// Let one edge pass so the next request never reuses this time step.
		@(posedge clk);
	endtask : xfer
endmodule : fcoe_host

/* File: verif/tb.sv */
// Self-checking bench of the fanout output enable control.
`timescale 1ns/100ps
`include "fcoe_defs.svh"
module tb;
	import fcoe_pkg::*;
	logic           clk, arst_n, mode, sck, din, sle, pen, rd, wr, wq, isw, pd, term, bias;
	logic           chk;      // Asks the monitor to sample the outputs.
	logic [7:0]     adr;
	logic [3:0]     be;
	fcoe_word_t     wdat, rdat;
	fcoe_drv_mask_t drv, osw, v, pm;
	fcoe_word_t     rq[$];    // Expected read data, oldest first.
	logic [19:0]    oq[$];    // Expected output vectors, oldest first.
	int             fails, cmp_count, cyc;
	integer         seed;
	int             ord[8] = '{2, 7, 4, 6, 5, 3, 8, 1};
	////////////////////////////////////////////////////////////////
	fcoe_host host (.clk(clk), .avs_waitrequest(wq), .interface_mode_select(mode),
		.serial_shift_clock(sck), .serial_data_input(din), .serial_latch_strobe(sle),
		.chip_power_enable(pen), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdat), .avs_byteenable(be));
	fcoe_top dut (.clk(clk), .arst_n(arst_n), .interface_mode_select(mode),
		.serial_shift_clock(sck), .serial_data_input(din), .serial_latch_strobe(sle),
		.chip_power_enable(pen), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wq), .driver_enable(drv), .output_switch_close(osw),
		.input_switch_close(isw), .power_down(pd), .term_150_select(term),
		.internal_bias_enable(bias));
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Expected outputs; a powered-down part has every switch open.
	function automatic logic [19:0] ex(input logic p, input logic t, input logic b,
		input fcoe_drv_mask_t d);
		return {p, ~p, t, b, p ? 8'h00 : d, p ? 8'h00 : d};
	endfunction : ex
	task automatic cmp_rd(input fcoe_word_t e, input fcoe_word_t g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_rd
	task automatic cmp_out(input logic [19:0] e, input logic [19:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_out
	// Monitor: read data at the answer edge, outputs when asked.
	always @(posedge clk) begin
		if (rd === 1'b1 && wq === 1'b0 && rq.size() > 0)
			cmp_rd(rq.pop_front(), rdat);
		if (chk === 1'b1 && oq.size() > 0)
			cmp_out(oq.pop_front(), {pd, isw, term, bias, drv, osw});
	end
	task automatic rdx(input logic [7:0] a, input fcoe_word_t e);
		rq.push_back(e);
		host.xfer(1'b0, a, 32'h0, 4'hf);
	endtask : rdx
	task automatic wrx(input logic [7:0] a, input fcoe_word_t d);
		host.xfer(1'b1, a, d, 4'h1);
	endtask : wrx
	// Pins need three edges to reach the outputs; one more gives margin.
	task automatic look(input logic [19:0] e);
		repeat (4) @(posedge clk);
		oq.push_back(e);
		chk <= 1'b1;
		@(posedge clk);
		chk <= 1'b0;
	endtask : look
	task automatic results();
		// Notes never matched by a result count against the run.
		fails += rq.size() + oq.size();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	// A hang is cut short well past the expected run length.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		seed   = 92;
		chk    = 1'b0;
		arst_n = 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rdx(`FCOE_OFS_POWER, 32'h1);
		rdx(`FCOE_OFS_OUT_ENABLE, 32'hff);
		rdx(`FCOE_OFS_IN_CONFIG, 32'h2);
		rdx(8'h40, 32'h0);
		look(ex(1'b0, 1'b0, 1'b1, 8'hff));
		$display("reset values done");
		// Register enables must be ignored while the code pins rule.
		wrx(`FCOE_OFS_OUT_ENABLE, 32'h0);
		pm = 8'h00;
		for (int c = 0; c < 8; c++) begin
			pm[ord[c] - 1] = 1'b1;
			host.pins(1'b1, 3'(c), 1'b1);
			look(ex(1'b0, 1'b0, 1'b1, pm));
		end
		$display("parallel codes done");
		for (int i = 0; i < 6; i++) begin
			v = 8'($random(seed));
			host.pins(1'b0, v[2:0], 1'b1);
			wrx(`FCOE_OFS_OUT_ENABLE, {24'h0, v});
			look(ex(1'b0, 1'b0, 1'b1, v));
		end
		host.xfer(1'b1, `FCOE_OFS_OUT_ENABLE, 32'h0, 4'h0);
		rdx(`FCOE_OFS_OUT_ENABLE, {24'h0, v});
		$display("serial enables done");
		host.pins(1'b0, 3'h0, 1'b0);
		look(ex(1'b1, 1'b0, 1'b1, v));
		wrx(`FCOE_OFS_OUT_ENABLE, 32'h5a);
		look(ex(1'b1, 1'b0, 1'b1, 8'h5a));
		host.pins(1'b0, 3'h0, 1'b1);
		look(ex(1'b0, 1'b0, 1'b1, 8'h5a));
		wrx(`FCOE_OFS_POWER, 32'h0);
		look(ex(1'b1, 1'b0, 1'b1, 8'h5a));
		rdx(`FCOE_OFS_POWER, 32'h0);
		wrx(`FCOE_OFS_POWER, 32'h1);
		look(ex(1'b0, 1'b0, 1'b1, 8'h5a));
		$display("power control done");
		wrx(`FCOE_OFS_IN_CONFIG, 32'h08);
		look(ex(1'b0, 1'b1, 1'b0, 8'h5a));
		wrx(`FCOE_OFS_IN_CONFIG, 32'hff);
		rdx(`FCOE_OFS_IN_CONFIG, 32'h0a);
		look(ex(1'b0, 1'b1, 1'b1, 8'h5a));
		rdx(`FCOE_OFS_STATUS, 32'h5a05);
		$display("input config done");
		results();
	end
endmodule : tb
